// >>> core/seew_core.v
// serial eeprom slave: address decode, byte/page write and program cycle
`timescale 1ns/1ps
`default_nettype none
`include "seew_defines.vh"
module seew_core #(
  parameter PGM_CYCLES = `SEEW_PGM_CYCLES
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // two-wire bus
  input  wire        sclIn,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  // straps and protect
  input  wire        chip_select_bit_hi,
  input  wire        chip_select_bit_mid,
  input  wire        chip_select_bit_lo,
  input  wire        writeProtect,
  // status
  output reg         busy_q,
  output reg         idLocked_q
);
  // protocol states, one per byte position in a write frame, plus idle and skip
  // idle: waiting for a start, bus otherwise ignored
  // dev: shifting the address byte (type, selects, direction)
  // adrh/adrl: the two word address bytes, upper one first
  // data: write data bytes, acked or refused per byte
  // skip: nacked or read frame, holds through the ack clock, then drops to idle
  // reads are not served here; a read address is acked and dropped
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV  = 3'h1;
  localparam ST_ADRH = 3'h2;
  localparam ST_ADRL = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_SKIP = 3'h5;

  // pin synchronisers and edge history
  // every pin is foreign to the system clock, so two flops each;
  // scl and sda share the same depth so their relative order holds,
  // which the start and stop detectors rely on
  // straps and protect are slow levels but still synchronised
  reg [1:0] sclSync_q;
  reg [1:0] sdaSync_q;
  reg       sclPrev_q;
  reg       sdaPrev_q;
  reg [1:0] strapSync0_q;
  reg [1:0] strapSync1_q;
  reg [1:0] strapSync2_q;
  reg [1:0] wpSync_q;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      strapSync0_q <= 2'h0;
      strapSync1_q <= 2'h0;
      strapSync2_q <= 2'h0;
      wpSync_q <= 2'h0;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
      strapSync0_q <= {strapSync0_q[0], chip_select_bit_lo};
      strapSync1_q <= {strapSync1_q[0], chip_select_bit_mid};
      strapSync2_q <= {strapSync2_q[0], chip_select_bit_hi};
      wpSync_q <= {wpSync_q[0], writeProtect};
    end
  end

  // edge and condition detectors on the synchronised lines
  // a start or stop needs scl high in two samples in a row, so a
  // data change at the same moment as the scl fall is never taken
  // for a condition
  // limitation: the bus clock must stay at least a few system
  // clocks in each phase, or edges merge in the synchroniser
  wire scl = sclSync_q[1];
  wire sda = sdaSync_q[1];
  wire sclRise = scl & ~sclPrev_q;
  wire sclFall = ~scl & sclPrev_q;
  wire startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
  wire stopCond = scl & sclPrev_q & ~sdaPrev_q & sda;
  wire protect = wpSync_q[1];
  wire [2:0] straps = {strapSync2_q[1], strapSync1_q[1], strapSync0_q[1]};

  // page buffer, committed to the array only on a valid stop
  // holding a whole page costs 64 bytes of flops but lets an aborted
  // frame leave the array untouched
  // valid bits record which page offsets the frame actually wrote,
  // so a partial page programs only those locations
  reg [7:0]  mainMem [0:32767];
  reg [7:0]  idPage [0:63];
  reg [7:0]  pageBuf [0:63];
  reg [63:0] bufValid_q;

  // frame state; a start condition clears the state, counters, valid bits, commit window
  // and lock request; the word address and decoded flags a new frame reloads anyway
  // commitOk_q marks the one window in which a stop programs:
  // from the ack clock of an accepted data byte through the high
  // phase of the clock that follows it
  reg [2:0]  state_q;
  reg [3:0]  bitCnt_q;
  reg [7:0]  shift_q;
  reg        ackPhase_q;
  reg        ackDrive_q;
  reg        isIdSpace_q;
  reg        isRead_q;
  reg [15:0] wordAddr_q;
  reg [6:0]  byteCnt_q;
  reg        commitOk_q;
  reg        dataNacked_q;
  reg        lockReq_q;
  reg        pgmIdPage_q;
  reg        pgmLock_q;
  reg [31:0] pgmCnt_q;
  reg [8:0]  pageRow_q;
  integer    i;

  // address byte decode: type, selects, direction
  // both type codes answer on the same selects; direction is
  // decided separately by the caller
  function devMatch;
    input [7:0] b;
    input [2:0] s;
    begin
      devMatch = ((b[7:4] == `SEEW_TYPE_MAIN) || (b[7:4] == `SEEW_TYPE_IDSP))
                 && (b[3:1] == s);
    end
  endfunction

  // byte assembly and write permission
  // rxByte includes the bit being sampled right now, so the byte is
  // complete at the eighth rise without waiting a cycle
  // protect refuses every data byte, lock bytes too; a locked id
  // page and the unique id function refuse data as well
  wire [7:0] rxByte = {shift_q[6:0], sda};
  wire       byteDone = sclRise & (bitCnt_q == 4'h7) & ~ackPhase_q;
  wire [2:0] idFn = wordAddr_q[11:9];
  wire       idPageWr = isIdSpace_q & (idFn == `SEEW_FN_IDPAGE);
  wire       lockWr = isIdSpace_q & (idFn == `SEEW_FN_LOCK);
  wire       dataBlocked = protect | (isIdSpace_q & idLocked_q)
                           | (isIdSpace_q & ~idPageWr & ~lockWr);

  // protocol engine
  // priority: busy first, so nothing on the bus is even seen while
  // programming; then start, then stop, then bit traffic
  // the ack is raised on the fall that ends bit eight and dropped
  // on the fall that ends the ninth clock, so sda is stable across
  // the whole high phase of the ack clock
  // a start at any point abandons the frame and its buffered data
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ackPhase_q <= 1'b0;
      ackDrive_q <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      isIdSpace_q <= 1'b0;
      isRead_q <= 1'b0;
      wordAddr_q <= 16'h0000;
      byteCnt_q <= 7'h00;
      commitOk_q <= 1'b0;
      dataNacked_q <= 1'b0;
      lockReq_q <= 1'b0;
      busy_q <= 1'b0;
      idLocked_q <= 1'b0;
      pgmIdPage_q <= 1'b0;
      pgmLock_q <= 1'b0;
      pgmCnt_q <= 32'h0;
      pageRow_q <= 9'h000;
      bufValid_q <= 64'h0;
    end
    else if (busy_q)
    begin
      // bus is ignored; the timer runs from the commit stop
      // polling during this time therefore sees no ack at all
      sdaOe <= 1'b0;
      if (pgmCnt_q == PGM_CYCLES - 1)
      begin
        busy_q <= 1'b0;
        pgmCnt_q <= 32'h0;
        if (pgmLock_q)
          idLocked_q <= 1'b1;
        bufValid_q <= 64'h0;
      end
      else
        pgmCnt_q <= pgmCnt_q + 32'h1;
    end
    else if (startCond)
    begin
      // restart discards anything pending
      state_q <= ST_DEV;
      bitCnt_q <= 4'h0;
      ackPhase_q <= 1'b0;
      sdaOe <= 1'b0;
      bufValid_q <= 64'h0;
      commitOk_q <= 1'b0;
      lockReq_q <= 1'b0;
      byteCnt_q <= 7'h00;
    end
    else if (stopCond)
    begin
      // commit only inside the window after an accepted data byte;
      // a frame with nothing buffered and no lock request is a
      // plain address set and programs nothing
      state_q <= ST_IDLE;
      sdaOe <= 1'b0;
      if (commitOk_q && (bufValid_q != 64'h0 || lockReq_q))
      begin
        busy_q <= 1'b1;
        pgmIdPage_q <= isIdSpace_q & ~lockReq_q;
        pgmLock_q <= lockReq_q;
        pageRow_q <= wordAddr_q[14:6];
      end
      else
        bufValid_q <= 64'h0;
      commitOk_q <= 1'b0;
    end
    else if (state_q != ST_IDLE)
    begin
      if (sclFall)
      begin
        // drive only after the falling edge
        sdaOe <= ackPhase_q & ackDrive_q;
        sdaOut <= 1'b0;
        if (!ackPhase_q && state_q == ST_SKIP)
          state_q <= ST_IDLE;
      end
      if (sclRise)
      begin
        // the stop arrives in the high phase of the clock after the
        // ack, so the window survives that one rise and closes at
        // the next; any later stop aborts the write
        if (bitCnt_q != 4'h0)
          commitOk_q <= 1'b0;
        if (ackPhase_q)
        begin
          ackPhase_q <= 1'b0;
          bitCnt_q <= 4'h0;
          if (state_q == ST_DATA && !dataNacked_q)
            commitOk_q <= 1'b1;
        end
        else
        begin
          shift_q <= rxByte;
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end
      if (byteDone)
      begin
        ackPhase_q <= 1'b1;
        ackDrive_q <= 1'b1;
        case (state_q)
          ST_DEV:
          begin
            isIdSpace_q <= (rxByte[7:4] == `SEEW_TYPE_IDSP);
            isRead_q <= rxByte[0];
            if (devMatch(rxByte, straps))
              state_q <= rxByte[0] ? ST_SKIP : ST_ADRH;
            else
            begin
              ackDrive_q <= 1'b0;
              state_q <= ST_SKIP;
            end
          end
          ST_ADRH:
          begin
            wordAddr_q[15:8] <= rxByte;
            state_q <= ST_ADRL;
          end
          ST_ADRL:
          begin
            wordAddr_q[7:0] <= rxByte;
            state_q <= ST_DATA;
          end
          ST_DATA:
          begin
            // refused bytes also drop what was buffered earlier, so a
            // protected frame can never commit a partial page
            // the offset wraps inside the page; the row never moves
            dataNacked_q <= dataBlocked;
            if (dataBlocked || (lockWr && !rxByte[`SEEW_LOCK_BIT]))
            begin
              ackDrive_q <= 1'b0;
              bufValid_q <= 64'h0;
              lockReq_q <= 1'b0;
            end
            else if (lockWr)
              lockReq_q <= 1'b1;
            else
            begin
              pageBuf[wordAddr_q[5:0]] <= rxByte;
              bufValid_q[wordAddr_q[5:0]] <= 1'b1;
            end
            wordAddr_q[5:0] <= wordAddr_q[5:0] + 6'h01;
            if (byteCnt_q != `SEEW_PAGE_BYTES)
              byteCnt_q <= byteCnt_q + 7'h01;
          end
          default:
          begin
            ackDrive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // array update at commit; wp not checked again since it gates every byte
  // done in the first busy cycle, long before the timer ends, so the
  // data is in place whenever the device answers again
  // no reset on the arrays: their contents survive a reset pulse
  always @(posedge clock)
  begin
    if (busy_q && pgmCnt_q == 32'h0 && !pgmLock_q)
    begin
      for (i = 0; i < `SEEW_PAGE_BYTES; i = i + 1)
      begin
        if (bufValid_q[i])
        begin
          if (pgmIdPage_q)
            idPage[i] <= pageBuf[i];
          else
            mainMem[{pageRow_q, i[5:0]}] <= pageBuf[i];
        end
      end
    end
  end
endmodule // seew_core
`default_nettype wire

// >>> core/seew_defines.vh
// constants for the serial eeprom address decode and write engine
`ifndef SEEW_DEFINES_VH
`define SEEW_DEFINES_VH
`define SEEW_TYPE_MAIN      4'hA
`define SEEW_TYPE_IDSP      4'hB
`define SEEW_FN_IDPAGE      3'h0
`define SEEW_FN_UID         3'h1
`define SEEW_FN_LOCK        3'h2
`define SEEW_PAGE_BYTES     64
`define SEEW_PGM_TIME_US    3000
`define SEEW_CLK_MHZ        200
`define SEEW_PGM_CYCLES     (`SEEW_PGM_TIME_US * `SEEW_CLK_MHZ)
`define SEEW_LOCK_BIT       1
`endif

// >>> sim/seew_chk_assertions.sv
// concurrent checks on the eeprom slave pins
`timescale 1ns/1ps
`default_nettype none
module seew_chk #(
  parameter PGM_CYCLES = 400
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // protect and status
  input wire logic writeProtect,
  input wire logic busy_q,
  input wire logic idLocked_q
);
  logic [31:0] busyCnt_q;
  // cycles spent busy, cleared while idle
  always_ff @(posedge clock or posedge rst)
    if (rst)
      busyCnt_q <= 32'h0;
    else
      busyCnt_q <= busy_q ? busyCnt_q + 32'h1 : 32'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a stop leaves both lines high
  sequence stopSeen;
    sclIn && sdaIn && !sdaOe;
  endsequence
  a_ack_low: assert property (sdaOe |-> !sdaOut)
    else $error("ack not low");
  a_busy_silent: assert property (busy_q |-> !sdaOe)
    else $error("ack while busy");
  a_busy_len: assert property ($fell(busy_q) |->
    busyCnt_q inside {[PGM_CYCLES-1:PGM_CYCLES+1]})
    else $error("program cycle length");
  a_ack_rise: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("ack raised with clock high");
  a_ack_fall: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("ack dropped with clock high");
  a_commit_stop: assert property ($rose(busy_q) |-> stopSeen)
    else $error("program without stop");
  a_protect_block: assert property (writeProtect |-> !$rose(busy_q))
    else $error("program while protected");
  a_lock_sticky: assert property (idLocked_q |=> idLocked_q)
    else $error("lock cleared");
  a_lock_idle: assert property ($rose(idLocked_q) |-> !busy_q)
    else $error("lock before cycle end");
endmodule // seew_chk
bind seew_core seew_chk #(.PGM_CYCLES(PGM_CYCLES)) chk (.clock(clock), .rst(rst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .writeProtect(writeProtect), .busy_q(busy_q), .idLocked_q(idLocked_q));
`default_nettype wire

// >>> sim/seew_core_tb_top.sv
// self-checking bench for the eeprom slave write engine
`timescale 1ns/1ps
`default_nettype none
module seew_core_tb_top;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       writeProtect = 1'b0;
  logic [2:0] strap = 3'h5;
  logic       ack;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         cyc = 0;
  wire logic  scl, sdaDrv, sdaOut, sdaOe, busy, locked;
  // open drain: device pulls low when enabled
  wire logic  sdaLine = sdaDrv && !(sdaOe && !sdaOut);
  seew_core #(.PGM_CYCLES(400)) uut (.clock(clock), .rst(rst), .sclIn(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chip_select_bit_hi(strap[2]),
    .chip_select_bit_mid(strap[1]), .chip_select_bit_lo(strap[0]),
    .writeProtect(writeProtect), .busy_q(busy), .idLocked_q(locked));
  seew_master m (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));
  initial forever #2.5 clock = ~clock;
  task automatic test_done;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, run needs about 50000 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic chk(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic adr(input logic [7:0] a, input logic e);
    m.start();
    m.tx(a, ack);
    chk(ack, e);
  endtask
  // address, word address, n data bytes each answered e
  task automatic wr(input logic [3:0] ty, input logic [15:0] wa, input int n, input logic e);
    adr({ty, strap, 1'b0}, 1'b1);
    m.tx(wa[15:8], ack);
    chk(ack, 1'b1);
    m.tx(wa[7:0], ack);
    chk(ack, 1'b1);
    // byte k carries k with bit 1 set, so lock data stays valid
    for (int k = 0; k < n; k++)
    begin
      m.tx(k[7:0] | 8'h02, ack);
      chk(ack, e);
    end
  endtask
  task automatic finish_write(input logic e);
    m.stop();
    chk(busy, e);
    if (e)
    begin
      adr({4'hA, strap, 1'b0}, 1'b0);
      m.stop();
    end
    repeat (2000) if (busy) @(negedge clock);
    chk(busy, 1'b0);
  endtask
  task automatic t_addr;
    for (int t = 0; t < 16; t++)
    begin
      adr({t[3:0], strap, t[0]}, t == 10 || t == 11);
      m.stop();
    end
    for (int s = 0; s < 8; s++)
    begin
      adr({4'hA, s[2:0], 1'b0}, s == 5);
      m.stop();
    end
    chk(busy, 1'b0);
    $display("address test done");
  endtask
  task automatic t_write(input logic wp);
    writeProtect = wp;
    wr(4'hA, 16'h8123, 1, !wp);
    finish_write(!wp);
    chk8(uut.mainMem[15'h0123], 8'h02);
    wr(4'hA, 16'h0040, 3, !wp);
    repeat (3) m.bitx(1'b1, ack);
    m.stop();
    chk(busy, 1'b0);
    wr(4'hA, 16'h1FC0, 66, !wp);
    finish_write(!wp);
    chk8(uut.mainMem[15'h1FC0], 8'h42);
    chk8(uut.mainMem[15'h1FFF], 8'h3F);
    writeProtect = 1'b0;
    $display("write test done");
  endtask
  task automatic t_lock;
    wr(4'hB, 16'h0200, 1, 1'b0);
    finish_write(1'b0);
    writeProtect = 1'b1;
    wr(4'hB, 16'h0400, 1, 1'b0);
    finish_write(1'b0);
    writeProtect = 1'b0;
    wr(4'hB, 16'h0400, 1, 1'b1);
    finish_write(1'b1);
    chk(locked, 1'b1);
    wr(4'hB, 16'h0400, 1, 1'b0);
    m.stop();
    $display("lock test done");
  endtask
  initial
  begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_addr;
    t_write(1'b0);
    t_write(1'b1);
    t_lock;
    test_done;
  end
endmodule // seew_core_tb_top
`default_nettype wire

// >>> sim/seew_master.sv
// two-wire bus master model, bus clock 125 ns
`timescale 1ns/1ps
`default_nettype none
module seew_master (
  // system clock and resolved data line
  input  wire logic clock,
  input  wire logic sdaLine,
  // bus drive, released lines idle high
  output var  logic scl,
  output var  logic sdaDrv
);
  // clock stands high between frames
  initial scl = 1'b1;
  initial sdaDrv = 1'b1;
  // set both lines, wait n clocks
  task automatic ph(input logic c, input logic d, input int n);
    scl = c;
    sdaDrv = d;
    repeat (n) @(negedge clock);
  endtask
  task automatic start;
    ph(scl, 1'b1, 6);
    ph(1'b1, 1'b1, 6);
    ph(1'b1, 1'b0, 6);
    ph(1'b0, 1'b0, 7);
  endtask
  task automatic stop;
    ph(1'b0, 1'b0, 6);
    ph(1'b1, 1'b0, 6);
    ph(1'b1, 1'b1, 13);
  endtask
  // data moves only while clock low, read mid high
  task automatic bitx(input logic b, output logic r);
    ph(1'b0, b, 6);
    ph(1'b1, b, 6);
    r = sdaLine;
    ph(1'b1, b, 6);
    ph(1'b0, b, 7);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
endmodule // seew_master
`default_nettype wire
